// file: design/ssc_regs.vh
// Constants for the serial stream concentrator
`ifndef SSC_REGS_VH
`define SSC_REGS_VH
`define SSC_NCHIP 12
`define SSC_ADDR_W 4
`define SSC_IN_W 9
`define SSC_OUT_W 13
`define SSC_IN_DEPTH 8
`define SSC_OUT_DEPTH 16
`define SSC_DROP_W 8
`define SSC_IN_FRAME 4'ha
`define SSC_OUT_FRAME 4'he
`define SSC_LINE_IDLE 1'b1
`define SSC_START_BIT 1'b0
`define SSC_STOP_BIT 1'b1
`define SSC_CLK_MHZ 10
`define SSC_BIT_MBPS 10
`define SSC_CYC_PER_BIT (`SSC_CLK_MHZ / `SSC_BIT_MBPS)
`endif

// file: design/ssc_top.v
// Serial stream concentrator: twelve chip receivers, merger, output link, control relay
`timescale 1ns/1ps
`include "ssc_regs.vh"

module ssc_fifo #(
  parameter W = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire ref_clk,
  input wire rst_b,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  // One bit wider than the pointers so full and empty stay apart
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage needs no reset; only the pointers and the count must start defined
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // ssc_fifo

module ssc_top #(
  parameter NCHIP = `SSC_NCHIP,
  parameter IN_DEPTH = `SSC_IN_DEPTH,
  parameter IN_AW = 3,
  parameter OUT_DEPTH = `SSC_OUT_DEPTH,
  parameter OUT_AW = 4,
  parameter DROP_W = `SSC_DROP_W
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [NCHIP-1:0] chip_ser_in,
  output reg merged_ser_out,
  input wire merged_link_hold,
  output wire [NCHIP*DROP_W-1:0] drop_count,
  input wire ctl_a_in,
  input wire ctl_b_in,
  output reg ctl_a_out,
  output reg ctl_b_out,
  input wire timestamp_counter_clear_in,
  output reg timestamp_counter_clear,
  output wire system_timing_clock
);
  localparam RX_IDLE = 1'b0;
  localparam RX_BITS = 1'b1;
  localparam TX_IDLE = 1'b0;
  localparam TX_SEND = 1'b1;

  wire [NCHIP-1:0] in_ok;
  wire [NCHIP*`SSC_IN_W-1:0] in_word;
  reg [NCHIP-1:0] in_pop;
  wire mrg_ready;
  reg mrg_valid;
  reg [`SSC_OUT_W-1:0] mrg_word;
  reg [`SSC_ADDR_W-1:0] rr_q;
  reg [`SSC_ADDR_W-1:0] pick;
  reg found;
  integer k;
  integer idx;

  // no flop can regenerate the system clock, so it is buffered straight out
  assign system_timing_clock = ref_clk;

  genvar g;
  generate
    for (g = 0; g < NCHIP; g = g + 1) begin : rx
      // Chips share our clock, so one sample per bit needs no oversampling
      reg state_q;
      reg [3:0] bit_q;
      reg [`SSC_IN_W:0] shf_q;
      reg push_q;
      reg [DROP_W-1:0] drop_q;
      wire ready;

      // one dedicated line per chip; 11-bit frames, start type data stop
      always @(posedge ref_clk) begin
        if (!rst_b) begin
          state_q <= RX_IDLE;
          bit_q <= 4'h0;
          shf_q <= {(`SSC_IN_W+1){1'b0}};
          push_q <= 1'b0;
        end else begin
          push_q <= 1'b0;
          case (state_q)
            RX_IDLE: begin
              // chips start frames on their own
              if (chip_ser_in[g] == `SSC_START_BIT) begin
                state_q <= RX_BITS;
                bit_q <= 4'h1;
              end
            end
            RX_BITS: begin
              shf_q <= {shf_q[`SSC_IN_W-1:0], chip_ser_in[g]};
              bit_q <= bit_q + 4'h1;
              if (bit_q == `SSC_IN_FRAME) begin
                state_q <= RX_IDLE;
                // A frame with a bad stop bit is discarded
                push_q <= (chip_ser_in[g] == `SSC_STOP_BIT);
              end
            end
            default: state_q <= RX_IDLE;
          endcase
        end
      end

      // full FIFO drops the new word and counts it, saturating
      // Saturation keeps a long overload from wrapping back to a small count
      always @(posedge ref_clk) begin
        if (!rst_b) begin
          drop_q <= {DROP_W{1'b0}};
        end else if (push_q && !ready && drop_q != {DROP_W{1'b1}}) begin
          drop_q <= drop_q + 1'b1;
        end
      end
      assign drop_count[g*DROP_W +: DROP_W] = drop_q;

      ssc_fifo #(
        .W(`SSC_IN_W),
        .DEPTH(IN_DEPTH),
        .AW(IN_AW)
      ) u_in_fifo (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .in_valid(push_q),
        .in_ready(ready),
        .in_data(shf_q[`SSC_IN_W:1]),
        .out_valid(in_ok[g]),
        .out_ready(in_pop[g]),
        .out_data(in_word[g*`SSC_IN_W +: `SSC_IN_W])
      );
    end
  endgenerate

  // search starts after the last served chip
  always @* begin
    found = 1'b0;
    pick = rr_q;
    idx = 0;
    for (k = 1; k <= NCHIP; k = k + 1) begin
      idx = (rr_q + k) % NCHIP;
      if (!found && in_ok[idx]) begin
        found = 1'b1;
        pick = idx[`SSC_ADDR_W-1:0];
      end
    end
  end

  // merge the chosen word; prepend the 4-bit chip index
  always @* begin
    in_pop = {NCHIP{1'b0}};
    mrg_valid = found;
    mrg_word = {pick, in_word[pick*`SSC_IN_W +: `SSC_IN_W]};
    if (found && mrg_ready) begin
      in_pop[pick] = 1'b1;
    end
  end

  // Pointer starts on the last chip so chip 0 is served first after reset
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      rr_q <= NCHIP[`SSC_ADDR_W-1:0] - 1'b1;
    end else if (found && mrg_ready) begin
      rr_q <= pick;
    end
  end

  wire out_ok;
  wire [`SSC_OUT_W-1:0] out_word;
  reg tx_state_q;
  reg [3:0] tx_cnt_q;
  reg [`SSC_OUT_W:0] tx_shf_q;
  wire tx_take;

  // Hold is looked at only between frames, never inside one
  assign tx_take = (tx_state_q == TX_IDLE) && out_ok && !merged_link_hold;

  // output buffer; a held link backs up into the input FIFOs
  ssc_fifo #(
    .W(`SSC_OUT_W),
    .DEPTH(OUT_DEPTH),
    .AW(OUT_AW)
  ) u_out_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(mrg_valid),
    .in_ready(mrg_ready),
    .in_data(mrg_word),
    .out_valid(out_ok),
    .out_ready(tx_take),
    .out_data(out_word)
  );

  // 15-bit frame, start addr type data stop, one bit per clock
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      tx_state_q <= TX_IDLE;
      tx_cnt_q <= 4'h0;
      tx_shf_q <= {(`SSC_OUT_W+1){1'b0}};
      merged_ser_out <= `SSC_LINE_IDLE;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          merged_ser_out <= `SSC_LINE_IDLE;
          if (tx_take) begin
            merged_ser_out <= `SSC_START_BIT;
            tx_shf_q <= {out_word, `SSC_STOP_BIT};
            tx_cnt_q <= 4'h1;
            tx_state_q <= TX_SEND;
          end
        end
        TX_SEND: begin
          // Hold only gates frame starts; a started frame always completes
          merged_ser_out <= tx_shf_q[`SSC_OUT_W];
          tx_shf_q <= {tx_shf_q[`SSC_OUT_W-1:0], `SSC_LINE_IDLE};
          tx_cnt_q <= tx_cnt_q + 4'h1;
          if (tx_cnt_q == `SSC_OUT_FRAME) begin
            tx_state_q <= TX_IDLE;
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // bit-for-bit relay, own flops, no decoding; is left to chips
  // One register stage only: latency costs nothing on this path
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      ctl_a_out <= `SSC_LINE_IDLE;
      ctl_b_out <= `SSC_LINE_IDLE;
    end else begin
      ctl_a_out <= ctl_a_in;
      ctl_b_out <= ctl_b_in;
    end
  end

  // one flop drives the shared clear line for all chips
  // Separate copies per bus could land on different edges and split the timestamps
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      timestamp_counter_clear <= 1'b0;
    end else begin
      timestamp_counter_clear <= timestamp_counter_clear_in;
    end
  end
endmodule // ssc_top

// file: bench/ssc_chip_model.sv
// Behavioural front-end chip pushing one frame per request
`timescale 1ns/1ps
module ssc_chip_model (
  input wire ref_clk,
  input wire go,
  input wire [8:0] w,
  output wire ser
);
  reg [10:0] sh_q = 11'h7ff;
  reg [3:0] n_q = 4'h0;
  assign ser = sh_q[10];
  always @(negedge ref_clk) begin
    if (n_q != 4'h0) begin
      sh_q <= {sh_q[9:0], 1'b1};
      n_q <= n_q - 4'h1;
    end else if (go) begin
      sh_q <= {1'b0, w, 1'b1};
      n_q <= 4'hb;
    end
  end
endmodule // ssc_chip_model

// file: bench/ssc_top_props.sv
// Port checker for the serial stream concentrator
`timescale 1ns/1ps
module ssc_top_props #(
  parameter NCHIP = 12,
  parameter DROP_W = 8
) (
  input wire ref_clk,
  input wire rst_b,
  input wire merged_ser_out,
  input wire merged_link_hold,
  input wire [NCHIP*DROP_W-1:0] drop_count,
  input wire ctl_a_in,
  input wire ctl_b_in,
  input wire ctl_a_out,
  input wire ctl_b_out,
  input wire timestamp_counter_clear_in,
  input wire timestamp_counter_clear
);
  reg [3:0] pos_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Bit position within an output frame, 0 while idle; wraps after the stop bit
  // because the next start may follow it at once
  always @(posedge ref_clk) begin
    if (!rst_b) pos_q <= 4'h0;
    else if (pos_q == 4'he) pos_q <= 4'h0;
    else if (pos_q != 4'h0 || !merged_ser_out) pos_q <= pos_q + 4'h1;
  end
  a_relay_a: assert property ($past(rst_b) |-> ctl_a_out == $past(ctl_a_in))
    else $error("bus A relay");
  a_relay_b: assert property ($past(rst_b) |-> ctl_b_out == $past(ctl_b_in))
    else $error("bus B relay");
  a_clear_fan: assert property ($past(rst_b) |-> timestamp_counter_clear ==
    $past(timestamp_counter_clear_in))
    else $error("clear fanout");
  a_reset_idle: assert property ($rose(rst_b) |-> merged_ser_out && drop_count == 0)
    else $error("reset state");
  a_hold_blocks: assert property (merged_link_hold [*8] ##1 merged_link_hold [*8]
    |-> merged_ser_out)
    else $error("frame under hold");
  a_drop_mono: assert property ($past(rst_b) |-> drop_count[31:24] >= $past(drop_count[31:24]))
    else $error("drop count fell");
  a_stop_bit: assert property (pos_q == 4'he |-> merged_ser_out)
    else $error("stop bit");
  a_addr_range: assert property (pos_q == 4'h2 && $past(merged_ser_out) |-> !merged_ser_out)
    else $error("address range");
  c_frame: cover property (pos_q == 4'he);
  c_drop: cover property (drop_count != 0);
  c_clear: cover property (timestamp_counter_clear);
endmodule // ssc_top_props

// file: bench/ssc_top_tb.sv
// Self-checking bench for the serial stream concentrator
`timescale 1ns/1ps
module ssc_top_tb;
  reg ref_clk = 1'b0;
  reg rst_b = 1'b0;
  reg hold = 1'b0, hf = 1'b0, ca = 1'b1, cb = 1'b1, tc = 1'b0;
  reg [11:0] go = 12'h000;
  reg [15:0] cwa = 16'hffff, cwb = 16'hffff;
  reg [107:0] w = 108'h0;
  reg [12:0] q[$];
  reg [13:0] got;
  wire [11:0] ser;
  wire [95:0] dc;
  wire so, stc, ctl_a, ctl_b, clr;
  integer fails = 0, total_checks = 0, cyc = 0, last = 11;
  // Words that fit in the output FIFO plus one input FIFO before drops start
  localparam integer STORED = 16 + 8;
  ssc_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .chip_ser_in(ser), .merged_ser_out(so),
    .merged_link_hold(hold), .drop_count(dc), .ctl_a_in(ca), .ctl_b_in(cb), .ctl_a_out(ctl_a),
    .ctl_b_out(ctl_b), .timestamp_counter_clear_in(tc), .timestamp_counter_clear(clr),
    .system_timing_clock(stc));
  // chips run from the fanned-out clock
  ssc_chip_model i_chip[11:0] (.ref_clk(stc), .go(go), .w(w), .ser(ser));
  initial forever #50 ref_clk = ~ref_clk;
  task results;
    begin
      if (fails == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [47:0] nm, input [15:0] e, input [15:0] g);
    begin
      total_checks = total_checks + 1;
      if (e !== g) begin
        fails = fails + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task burst(input [11:0] m, input fix, input note);
    reg [8:0] v[0:11];
    integer k, b, t;
    begin
      b = last;
      for (k = 0; k < 12; k = k + 1) begin
        v[k] = fix ? 9'h0a5 : 9'($urandom);
        w[9*k +: 9] <= v[k];
      end
      go <= m;
      @(negedge ref_clk);
      go <= 12'h000;
      // served from the chip after the last one
      for (k = 1; k < 13; k = k + 1) begin
        t = (b + k) % 12;
        if (m[t]) last = t;
        if (m[t] && note) q.push_back({4'(t), v[t]});
      end
      repeat (11) @(negedge ref_clk);
    end
  endtask
  task drain;
    integer n;
    begin
      for (n = 0; n < 3000 && q.size() != 0; n = n + 1) @(negedge ref_clk);
      chk("left", 16'h0, 16'(q.size()));
    end
  endtask
  // Decode each output frame and compare with the oldest note
  initial forever begin
    @(negedge ref_clk);
    if (so === 1'b0) begin
      repeat (14) begin
        @(negedge ref_clk);
        got = {got[12:0], so};
      end
      chk("stop", 16'h1, {15'h0, got[0]});
      if (q.size() == 0)
        chk("extra", 16'hffff, {3'h0, got[13:1]});
      else
        chk("word", {3'h0, q.pop_front()}, {3'h0, got[13:1]});
    end
  end
  always @(negedge ref_clk) begin
    if (rst_b) chk("relay", {13'h0, ca, cb, tc}, {13'h0, ctl_a, ctl_b, clr});
    // every control word names a chip of its own bus: A 0-5, B 6-11
    if (cyc % 16 == 0) begin
      cwa <= {1'b0, 4'($urandom % 6), 8'($urandom), 3'h7};
      cwb <= {1'b0, 4'(6 + $urandom % 6), 8'($urandom), 3'h7};
    end else begin
      cwa <= {cwa[14:0], 1'b1};
      cwb <= {cwb[14:0], 1'b1};
    end
    {ca, cb} <= {cwa[15], cwb[15]};
    tc <= ($urandom % 8) == 0;
    hold <= hf || ($urandom % 4) == 0;
  end
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 10000) begin
      fails = fails + 1;
      results;
    end
  end
  initial begin
    void'($urandom(32));
    repeat (8) @(negedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(negedge ref_clk);
    burst(12'hfff, 1'b0, 1'b1);
    drain;
    repeat (6) begin
      burst(12'($urandom), 1'b0, 1'b1);
      drain;
    end
    // Equal words make the surviving set independent of which got dropped
    hf <= 1'b1;
    repeat (30) burst(12'h008, 1'b1, 1'b0);
    repeat (4) @(negedge ref_clk);
    chk("drop", 16'(30 - STORED), {8'h0, dc[31:24]});
    chk("drop_x", 16'h0, {15'h0, |{dc[95:32], dc[23:0]}});
    repeat (STORED) q.push_back({4'h3, 9'h0a5});
    hf <= 1'b0;
    drain;
    results;
  end
endmodule // ssc_top_tb
bind ssc_top ssc_top_props #(.NCHIP(NCHIP), .DROP_W(DROP_W)) i_props (.ref_clk(ref_clk),
  .rst_b(rst_b), .merged_ser_out(merged_ser_out), .merged_link_hold(merged_link_hold),
  .drop_count(drop_count), .ctl_a_in(ctl_a_in), .ctl_b_in(ctl_b_in), .ctl_a_out(ctl_a_out),
  .ctl_b_out(ctl_b_out), .timestamp_counter_clear_in(timestamp_counter_clear_in),
  .timestamp_counter_clear(timestamp_counter_clear));
